//--- ccp_host_model.sv
// host-side reader that drains phy counter log pages, optionally stalling
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bench control
  input wire logic stallMode,
  input wire logic armLog,
  // log stream
  input wire logic logValid,
  input wire logic logLast,
  input wire logic [15:0] logWord,
  output logic logReady,
  output logic [8:0] wordCount,
  output logic [8:0] lastIdx
);
  logic [15:0] words [0:255];
  // every other cycle stalled so the device must hold each word
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      logReady <= 1'b0;
    end else begin
      logReady <= stallMode ? ~logReady : 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || armLog) begin
      wordCount <= 9'h000;
      lastIdx <= 9'h1ff;
    end else if (logValid && logReady) begin
      words[wordCount[7:0]] <= logWord;
      if (logLast) begin
        lastIdx <= wordCount;
      end
      wordCount <= wordCount + 9'h001;
    end
  end
endmodule
`default_nettype wire

//--- ccp_pkg.sv
// shared types and constants for settings retention and phy event counters
`default_nettype none
package ccp_pkg;

  // set features subcommands
  localparam logic [7:0] SF_WCACHE_ON = 8'h02;
  localparam logic [7:0] SF_WCACHE_OFF = 8'h82;
  localparam logic [7:0] SF_XFER_MODE = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_KEEP_ON = 8'h06;
  localparam logic [7:0] SF_KEEP_OFF = 8'h86;
  localparam logic [7:0] SF_RLA_OFF = 8'h55;
  localparam logic [7:0] SF_RLA_ON = 8'haa;
  localparam logic [7:0] SF_REVERT_OFF = 8'h66;
  localparam logic [7:0] SF_REVERT_ON = 8'hcc;
  // transfer mode type, sector count bits 7:3
  localparam logic [4:0] XM_PIO = 5'h01;
  localparam logic [4:0] XM_MDMA = 5'h04;
  localparam logic [4:0] XM_UDMA = 5'h08;

  // phy event counter log layout, 16-bit words
  localparam logic [7:0] LOG_PAGE_ID = 8'h11;
  localparam int NUM_CNT = 3;
  localparam logic [7:0] LOG_LAST_WORD = 8'hff;
  localparam logic [7:0] LOG_FIRST_CNT = 8'h02;
  localparam logic [7:0] LOG_END_WORD = 8'h0b;
  localparam logic [2:0] CNT_SIZE_32 = 3'h2;
  localparam logic [11:0] CID_END = 12'h000;
  localparam logic [11:0] CID_ICRC = 12'h001;
  localparam logic [11:0] CID_PHYRDY = 12'h009;
  localparam logic [11:0] CID_SIGFIS = 12'h00a;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;

  // power-on defaults
  localparam logic [47:0] DEF_MAX_LBA = 48'h0000_0fff_ffff;
  localparam logic [2:0] DEF_UNLOCK_TRIES = 3'h5;
  localparam logic [7:0] DEF_APM_LEVEL = 8'hfe;
  localparam logic [7:0] DEF_MULT_BLOCK = 8'h10;

  typedef enum logic [3:0] {
    OP_SETFEAT = 4'h0, OP_INITPARAM = 4'h1, OP_STANDBY = 4'h2, OP_SETMAX = 4'h3,
    OP_SETMULT = 4'h4, OP_FREEZE = 4'h5, OP_UNLOCK_FAIL = 4'h6, OP_SECSTATE = 4'h7,
    OP_RSTREAM_ERR = 4'h8, OP_WSTREAM_ERR = 4'h9
  } ccp_op_e;

  typedef enum logic [5:0] {
    SEC1 = 6'h01, SEC2 = 6'h02, SEC3 = 6'h04, SEC4 = 6'h08, SEC5 = 6'h10, SEC6 = 6'h20
  } ccp_sec_e;

  typedef enum logic [1:0] {LOG_IDLE = 2'b01, LOG_SEND = 2'b10} ccp_log_e;

  typedef struct packed {
    logic valid;
    ccp_op_e op;
    logic [7:0] sub;
    logic [7:0] count;
    logic [47:0] value;
  } ccp_cmd_s;

  typedef struct packed {
    logic valid;
    logic farAnalog;
    logic retimed;
    logic txOnly;
    logic alignBypass;
    logic scramBypass;
  } ccp_bist_s;

  typedef struct packed {
    logic [15:0] cylinders;
    logic [7:0] heads;
    logic [7:0] sectors;
    logic [7:0] standbyTimer;
    logic [7:0] readStreamErrs;
    logic [7:0] writeStreamErrs;
    logic frozen;
    logic [2:0] unlockLeft;
    logic [47:0] maxLba;
    logic writeCache;
    logic [2:0] pioMode;
    logic [2:0] mdmaMode;
    logic [2:0] udmaMode;
    logic apmEn;
    logic [7:0] apmLevel;
    logic lookAhead;
    logic revertDefaults;
    logic [7:0] multBlock;
  } ccp_set_s;

  localparam ccp_set_s SET_DEFAULT = '{
    cylinders: 16'h0000, heads: 8'h00, sectors: 8'h00, standbyTimer: 8'h00,
    readStreamErrs: 8'h00, writeStreamErrs: 8'h00, frozen: 1'b0,
    unlockLeft: DEF_UNLOCK_TRIES, maxLba: DEF_MAX_LBA, writeCache: 1'b1,
    pioMode: 3'h4, mdmaMode: 3'h2, udmaMode: 3'h6, apmEn: 1'b0,
    apmLevel: DEF_APM_LEVEL, lookAhead: 1'b1, revertDefaults: 1'b0,
    multBlock: DEF_MULT_BLOCK
  };

endpackage
`default_nettype wire

//--- ccp_retention_counters.sv
// settings kept across link reset, bist entry and phy event counters with log readout
// Functional notes
// - bist activate enters self-test; align/scramble bypass only allowed with transmit-only
// - subcommand 06h enables, 86h disables settings retention across link reset
// - retention enabled after power-on without any host command
// - link reset acts as hardware reset, whether requested or not
// - settings retained only for features this block implements
// - geometry parameters and standby timer kept across link reset
// - read and write stream error logs kept across link reset
// - security state never changes because of link reset
// - frozen flag and remaining unlock attempts kept across link reset
// - maximum user lba from set-max commands kept across link reset
// - write cache enable from 02h/82h kept across link reset
// - pio, mdma, udma mode selections from 03h kept across link reset
// - apm enable and level from 05h/85h kept across link reset
// - read look-ahead from 55h/aah kept across link reset
// - revert-to-defaults enable from cch/66h kept across link reset
// - multiple-sector block size kept across link reset
// - identify word 76 bit 10 reports counter support
// - log page 11h read returns the counter values
// - counters survive link and software reset, cleared at power-on
// - all mandatory counters implemented, optional ones selectively
// - bist activate returns every counter to its reset value
// - page 11h read with features bit 0 returns values then clears
// - each entry starts with 16-bit id, bits 14:12 give counter size
// - id 000h ends the list; counter 001h counts icrc-failed commands
`timescale 1ns/1ps
`default_nettype none
module ccp_retention_counters
  import ccp_pkg::*;
(
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link and software resets
  input wire logic comReset,
  input wire logic softReset,
  // decoded commands
  input wire ccp_cmd_s cmd,
  // bist activate fis
  input wire ccp_bist_s bist,
  // phy events
  input wire logic evtIcrcCmd,
  input wire logic evtPhyRdy,
  input wire logic evtSigFis,
  // log page read
  input wire logic logReq,
  input wire logic [7:0] logPage,
  input wire logic [7:0] logFeatures,
  input wire logic logReady,
  output logic logValid,
  output logic logLast,
  output logic [15:0] logWord,
  // settings and status
  output ccp_set_s settings,
  output ccp_sec_e secState,
  output logic preserveEn,
  output logic identPhyCnt,
  output logic bistActive,
  output logic [4:0] bistMode,
  output logic bistReject
);

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
  endfunction

  function automatic logic [15:0] cnt_id(input logic [11:0] id);
    cnt_id = {1'b0, CNT_SIZE_32, id};
  endfunction

  // entry k: id word, low half, high half; then the end marker
  function automatic logic [15:0] word_at(input logic [7:0] idx,
                                          input logic [NUM_CNT*32-1:0] snap);
    logic [7:0] rel;
    logic [1:0] part;
    logic [1:0] slot;
    rel = idx - LOG_FIRST_CNT;
    part = 2'(rel % 8'h03);
    slot = 2'(rel / 8'h03);
    word_at = 16'h0000;
    if (idx >= LOG_FIRST_CNT && idx < LOG_END_WORD) begin
      case (part)
        2'd0: word_at = cnt_id(slot == 2'd0 ? CID_ICRC : slot == 2'd1 ? CID_PHYRDY : CID_SIGFIS);
        2'd1: word_at = snap[slot*32 +: 16];
        default: word_at = snap[slot*32+16 +: 16];
      endcase
    end else if (idx == LOG_END_WORD) begin
      word_at = {4'h0, CID_END};
    end
  endfunction

  // ---------------- settings retention ----------------
  ccp_set_s next_settings;
  logic next_preserveEn;
  ccp_sec_e next_secState;
  wire logic cmdOk = cmd.valid && !comReset;
  wire logic isSetFeat = cmdOk && cmd.op == OP_SETFEAT;
  wire logic [4:0] xferType = cmd.count[7:3];

  // all listed features exist here, so every listed setting is retained
  always_comb begin
    next_settings = settings;
    next_preserveEn = preserveEn;
    next_secState = secState;
    if (comReset) begin
      // a lost-signal reset looks identical, so nothing distinguishes the two
      if (!preserveEn) begin
        next_settings = SET_DEFAULT;
      end
    end else if (cmd.valid) begin
      case (cmd.op)
        OP_SETFEAT: begin
          case (cmd.sub)
            SF_KEEP_ON: next_preserveEn = 1'b1;
            SF_KEEP_OFF: next_preserveEn = 1'b0;
            SF_WCACHE_ON: next_settings.writeCache = 1'b1;
            SF_WCACHE_OFF: next_settings.writeCache = 1'b0;
            SF_XFER_MODE: begin
              if (xferType == XM_PIO) next_settings.pioMode = cmd.count[2:0];
              if (xferType == XM_MDMA) next_settings.mdmaMode = cmd.count[2:0];
              if (xferType == XM_UDMA) next_settings.udmaMode = cmd.count[2:0];
            end
            SF_APM_ON: begin
              next_settings.apmEn = 1'b1;
              next_settings.apmLevel = cmd.count;
            end
            SF_APM_OFF: next_settings.apmEn = 1'b0;
            SF_RLA_OFF: next_settings.lookAhead = 1'b0;
            SF_RLA_ON: next_settings.lookAhead = 1'b1;
            SF_REVERT_OFF: next_settings.revertDefaults = 1'b0;
            SF_REVERT_ON: next_settings.revertDefaults = 1'b1;
            default: next_settings = settings;
          endcase
        end
        OP_INITPARAM: begin
          next_settings.sectors = cmd.count;
          next_settings.heads = cmd.value[7:0];
          next_settings.cylinders = cmd.value[23:8];
        end
        OP_STANDBY: next_settings.standbyTimer = cmd.count;
        OP_SETMAX: next_settings.maxLba = cmd.value;
        OP_SETMULT: next_settings.multBlock = cmd.count;
        OP_FREEZE: next_settings.frozen = 1'b1;
        OP_UNLOCK_FAIL: begin
          if (settings.unlockLeft != 3'h0) begin
            next_settings.unlockLeft = settings.unlockLeft - 3'h1;
          end
        end
        OP_SECSTATE: next_secState = ccp_sec_e'(cmd.value[5:0]);
        OP_RSTREAM_ERR: next_settings.readStreamErrs = settings.readStreamErrs + 8'h01;
        OP_WSTREAM_ERR: next_settings.writeStreamErrs = settings.writeStreamErrs + 8'h01;
        default: next_settings = settings;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settings <= SET_DEFAULT;
      preserveEn <= 1'b1;
      secState <= SEC1;
      identPhyCnt <= 1'b0;
    end else begin
      settings <= next_settings;
      preserveEn <= next_preserveEn;
      secState <= next_secState; // link reset never moves this
      identPhyCnt <= 1'b1;
    end
  end

  // ---------------- bist ----------------
  wire logic oneLoop =
    ({1'b0, bist.farAnalog} + {1'b0, bist.retimed} + {1'b0, bist.txOnly}) == 2'd1;
  wire logic bypassOk = bist.txOnly || !(bist.alignBypass || bist.scramBypass);
  wire logic bistOk = bist.valid && oneLoop && bypassOk;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bistActive <= 1'b0;
      bistMode <= 5'h00;
      bistReject <= 1'b0;
    end else begin
      bistReject <= bist.valid && !bistOk;
      // entry landing with a link reset wins, unlike a command, which the link reset drops
      if (bistOk) begin
        bistActive <= 1'b1;
        bistMode <= {bist.farAnalog, bist.retimed, bist.txOnly, bist.alignBypass,
                     bist.scramBypass};
      end else if (comReset) begin
        bistActive <= 1'b0;
      end
    end
  end

  // ---------------- phy event counters ----------------
  // one mandatory icrc counter, one mandatory signature counter, optional phyrdy
  logic [31:0] cnt [NUM_CNT];
  logic [NUM_CNT*32-1:0] snap;
  ccp_log_e logState;
  logic [7:0] wordIdx;
  wire logic [NUM_CNT-1:0] evt = {evtSigFis, evtPhyRdy, evtIcrcCmd};
  wire logic logStart = logReq && logPage == LOG_PAGE_ID && logState == LOG_IDLE;
  // a request refused under soft reset sends nothing, so it must not clear
  wire logic clrAfter = logStart && !softReset && logFeatures[0];
  wire logic cntClear = bist.valid || clrAfter;
  wire logic logStep = logState == LOG_SEND && logReady;
  wire logic [NUM_CNT*32-1:0] cntFlat = {cnt[2], cnt[1], cnt[0]};

  // an event in the clearing cycle counts as one, so none is lost
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NUM_CNT; i++) begin
      if (!rst_n) begin
        cnt[i] <= CNT_RESET;
      end else if (cntClear) begin
        cnt[i] <= evt[i] ? 32'h0000_0001 : CNT_RESET;
      end else if (evt[i]) begin
        cnt[i] <= sat_inc(cnt[i]);
      end
    end
  end

  // snapshot taken before the clear lands, so the page shows pre-clear values
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      logState <= LOG_IDLE;
      wordIdx <= 8'h00;
      snap <= '0;
      logWord <= 16'h0000;
    end else begin
      case (logState)
        LOG_IDLE: begin
          if (logStart && !softReset) begin
            snap <= cntFlat;
            wordIdx <= 8'h00;
            logWord <= word_at(8'h00, cntFlat);
            logState <= LOG_SEND;
          end
        end
        LOG_SEND: begin
          // software reset aborts the transfer but leaves counters alone
          if (softReset || comReset || (logStep && wordIdx == LOG_LAST_WORD)) begin
            logState <= LOG_IDLE;
          end else if (logStep) begin
            wordIdx <= wordIdx + 8'h01;
            logWord <= word_at(wordIdx + 8'h01, snap);
          end
        end
        default: logState <= LOG_IDLE;
      endcase
    end
  end

  assign logValid = logState == LOG_SEND;
  assign logLast = logValid && wordIdx == LOG_LAST_WORD;

  // ---------------- checks ----------------
  a_bist_bypass_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bistActive |-> (bistMode[2] || bistMode[1:0] == 2'b00))
    else $error("bypass mode active without transmit-only");

  a_poweron_keep: assert property (@(posedge sys_clk)
    $past(!rst_n) && rst_n |-> preserveEn)
    else $error("retention not enabled after power-on");

  a_keep_settings: assert property (@(posedge sys_clk) disable iff (!rst_n)
    comReset && preserveEn |=> settings == $past(settings) ##1 settings == $past(settings)
      || $past(cmd.valid))
    else $error("retained settings changed across link reset");

  a_revert_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
    comReset && !preserveEn |=> settings == SET_DEFAULT)
    else $error("defaults not restored on link reset");

  a_sec_state_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    comReset |=> secState == $past(secState))
    else $error("security state moved on link reset");

  a_wcache_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    isSetFeat && cmd.sub == SF_WCACHE_OFF |=> !settings.writeCache)
    else $error("write cache disable not applied");

  a_bist_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bist.valid |=> cnt[0] <= 32'h0000_0001 && cnt[2] <= 32'h0000_0001)
    else $error("counters not cleared by bist activate");

  a_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrAfter |=> snap[31:0] == $past(cnt[0]) && cnt[0] <= 32'h0000_0001)
    else $error("read-and-clear order wrong");

  a_entry_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
    logValid && wordIdx == LOG_FIRST_CNT |-> logWord[14:12] == CNT_SIZE_32)
    else $error("counter size field wrong");

  a_list_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    logValid && wordIdx == LOG_END_WORD |-> logWord == 16'h0000)
    else $error("end marker missing");

  a_softreset_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    softReset && !cntClear && evt == '0 |=> cnt[1] == $past(cnt[1]))
    else $error("counter lost on software reset");

endmodule
`default_nettype wire

//--- ccp_retention_counters_tb_top.sv
// self-checking bench for settings retention, bist entry and phy counters
`timescale 1ns/1ps
`default_nettype none
module ccp_retention_counters_tb_top import ccp_pkg::*;;
  logic sys_clk = 1'b0, rst_n = 1'b0, comReset = 1'b0, softReset = 1'b0;
  logic evtIcrcCmd = 1'b0, evtPhyRdy = 1'b0, evtSigFis = 1'b0;
  logic logReq = 1'b0, logReady, stallMode = 1'b0, armLog = 1'b0;
  logic [7:0] logPage = 8'h00, logFeatures = 8'h00;
  ccp_cmd_s cmd = '0;
  ccp_bist_s bist = '0;
  logic logValid, logLast, preserveEn, identPhyCnt, bistActive, bistReject;
  logic [15:0] logWord;
  logic [4:0] bistMode;
  logic [8:0] wordCount, lastIdx;
  ccp_set_s settings, want;
  ccp_sec_e secState;
  int err_total = 0, comparisons = 0;
  logic [11:0] ids [3] = '{CID_ICRC, CID_PHYRDY, CID_SIGFIS};
  // bit 5 marks an accepted combination, bits 4:0 are f,l,t,a,s
  logic [5:0] bistTab [8] = '{6'h30, 6'h28, 6'h24, 6'h26, 6'h25, 6'h00, 6'h18, 6'h12};

  always #4 sys_clk = ~sys_clk;

  ccp_retention_counters u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .comReset(comReset),
    .softReset(softReset), .cmd(cmd), .bist(bist), .evtIcrcCmd(evtIcrcCmd),
    .evtPhyRdy(evtPhyRdy), .evtSigFis(evtSigFis), .logReq(logReq), .logPage(logPage),
    .logFeatures(logFeatures), .logReady(logReady), .logValid(logValid), .logLast(logLast),
    .logWord(logWord), .settings(settings), .secState(secState), .preserveEn(preserveEn),
    .identPhyCnt(identPhyCnt), .bistActive(bistActive), .bistMode(bistMode),
    .bistReject(bistReject));
  ccp_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .stallMode(stallMode),
    .armLog(armLog), .logValid(logValid), .logLast(logLast), .logWord(logWord),
    .logReady(logReady), .wordCount(wordCount), .lastIdx(lastIdx));

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp48, input string what);
    comparisons++;
    if (got !== exp48) begin
      err_total++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp48);
    end
  endtask
  task automatic chk_set(input ccp_set_s got, input ccp_set_s exps, input string what);
    comparisons++;
    if (got !== exps) begin
      err_total++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exps);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic send_cmd(input ccp_op_e op, input logic [7:0] sub, input logic [7:0] cnt,
                          input logic [47:0] val);
    cmd = '{1'b1, op, sub, cnt, val};
    tick;
    cmd = '0;
    tick;
  endtask
  task automatic pulse_reset(input logic link);
    if (link) comReset = 1'b1;
    else softReset = 1'b1;
    tick;
    comReset = 1'b0;
    softReset = 1'b0;
    tick;
  endtask
  task automatic pulse_events(input int ni, input int np, input int ns);
    for (int i = 0; i < 8; i++) begin
      evtIcrcCmd = (i < ni);
      evtPhyRdy = (i < np);
      evtSigFis = (i < ns);
      tick;
    end
    {evtIcrcCmd, evtPhyRdy, evtSigFis} = 3'h0;
    tick;
  endtask
  // reads page 11h to the end and checks every word of it
  task automatic read_log(input logic [7:0] feat, input logic stall, input logic [31:0] c0,
                          input logic [31:0] c1, input logic [31:0] c2);
    logic [31:0] cv [3];
    logic [15:0] w16;
    int k;
    cv = '{c0, c1, c2};
    logPage = LOG_PAGE_ID;
    logFeatures = feat;
    stallMode = stall;
    logReq = 1'b1;
    armLog = 1'b1;
    tick;
    logReq = 1'b0;
    armLog = 1'b0;
    for (int i = 0; i < 1200 && wordCount != 9'h100; i++) tick;
    tick;
    chk(48'(logValid), 48'h0, "valid after page");
    chk(48'(lastIdx), 48'h0ff, "last flag index");
    for (int w = 0; w < 256; w++) begin
      w16 = 16'h0000;
      if (w >= 2 && w <= 10) begin
        k = (w - 2) / 3;
        case ((w - 2) % 3)
          0: w16 = {1'b0, CNT_SIZE_32, ids[k]};
          1: w16 = cv[k][15:0];
          default: w16 = cv[k][31:16];
        endcase
      end
      chk(48'(u_host.words[w]), 48'(w16), "log word");
    end
  endtask

  task automatic test_reset;
    chk(48'(preserveEn), 48'h1, "keep after power-on");
    chk(48'(identPhyCnt), 48'h1, "counter support");
    chk_set(settings, SET_DEFAULT, "defaults");
    $display("test reset done");
  endtask
  task automatic test_retain;
    want = SET_DEFAULT;
    want.writeCache = 1'b0;
    want.pioMode = 3'h2;
    want.mdmaMode = 3'h1;
    want.udmaMode = 3'h3;
    {want.apmEn, want.apmLevel, want.lookAhead, want.revertDefaults} = {1'b1, 8'h80, 2'b01};
    {want.multBlock, want.sectors, want.heads, want.cylinders} = 40'h08_3f_0f_1234;
    {want.standbyTimer, want.maxLba, want.frozen, want.unlockLeft} = {8'h24, 48'h1234_5678, 4'hc};
    {want.readStreamErrs, want.writeStreamErrs} = 16'h0102;
    send_cmd(OP_SETFEAT, SF_WCACHE_OFF, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_XFER_MODE, {XM_PIO, 3'h2}, 48'h0);
    send_cmd(OP_SETFEAT, SF_XFER_MODE, {XM_MDMA, 3'h1}, 48'h0);
    send_cmd(OP_SETFEAT, SF_XFER_MODE, {XM_UDMA, 3'h3}, 48'h0);
    send_cmd(OP_SETFEAT, SF_APM_ON, 8'h80, 48'h0);
    send_cmd(OP_SETFEAT, SF_RLA_OFF, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_REVERT_ON, 8'h00, 48'h0);
    send_cmd(OP_SETMULT, 8'h00, 8'h08, 48'h0);
    send_cmd(OP_INITPARAM, 8'h00, 8'h3f, 48'h12_340f);
    send_cmd(OP_STANDBY, 8'h00, 8'h24, 48'h0);
    send_cmd(OP_SETMAX, 8'h00, 8'h00, 48'h1234_5678);
    send_cmd(OP_FREEZE, 8'h00, 8'h00, 48'h0);
    send_cmd(OP_UNLOCK_FAIL, 8'h00, 8'h00, 48'h0);
    send_cmd(OP_RSTREAM_ERR, 8'h00, 8'h00, 48'h0);
    send_cmd(OP_WSTREAM_ERR, 8'h00, 8'h00, 48'h0);
    send_cmd(OP_WSTREAM_ERR, 8'h00, 8'h00, 48'h0);
    send_cmd(OP_SECSTATE, 8'h00, 8'h00, 48'(SEC5));
    chk_set(settings, want, "programmed");
    // a command landing with the link reset is dropped
    cmd = '{1'b1, OP_SETFEAT, SF_WCACHE_ON, 8'h00, 48'h0};
    comReset = 1'b1;
    tick;
    cmd = '0;
    comReset = 1'b0;
    tick;
    chk_set(settings, want, "kept");
    chk(48'(secState), 48'(SEC5), "security kept");
    $display("test retain done");
  endtask
  task automatic test_nokeep;
    send_cmd(OP_SETFEAT, SF_KEEP_OFF, 8'h00, 48'h0);
    chk(48'(preserveEn), 48'h0, "keep off");
    pulse_reset(1'b1);
    chk_set(settings, SET_DEFAULT, "reverted");
    chk(48'(secState), 48'(SEC5), "security kept");
    want = SET_DEFAULT;
    want.apmLevel = 8'h40;
    want.unlockLeft = 3'h0;
    send_cmd(OP_SETFEAT, SF_WCACHE_OFF, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_WCACHE_ON, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_APM_ON, 8'h40, 48'h0);
    send_cmd(OP_SETFEAT, SF_APM_OFF, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_RLA_OFF, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_RLA_ON, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_REVERT_ON, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, SF_REVERT_OFF, 8'h00, 48'h0);
    send_cmd(OP_SETFEAT, 8'h77, 8'h00, 48'h0);
    repeat (6) send_cmd(OP_UNLOCK_FAIL, 8'h00, 8'h00, 48'h0);
    chk_set(settings, want, "toggled back");
    send_cmd(OP_SETFEAT, SF_KEEP_ON, 8'h00, 48'h0);
    chk(48'(preserveEn), 48'h1, "keep on");
    $display("test nokeep done");
  endtask
  task automatic test_bist;
    for (int i = 0; i < 8; i++) begin
      bist = '{1'b1, bistTab[i][4], bistTab[i][3], bistTab[i][2], bistTab[i][1], bistTab[i][0]};
      tick;
      bist = '0;
      chk(48'(bistReject), 48'(!bistTab[i][5]), "bist refused");
      chk(48'(bistActive), 48'(bistTab[i][5]), "bist active");
      if (bistTab[i][5]) chk(48'(bistMode), 48'(bistTab[i][4:0]), "bist mode");
      pulse_reset(1'b1);
      chk(48'(bistActive), 48'h0, "bist left");
    end
    $display("test bist done");
  endtask
  task automatic test_counters;
    pulse_events(3, 5, 2);
    pulse_reset(1'b1);
    pulse_reset(1'b0);
    read_log(8'h00, 1'b1, 32'd3, 32'd5, 32'd2);
    logPage = 8'h10;
    logReq = 1'b1;
    tick;
    logReq = 1'b0;
    tick;
    chk(48'(logValid), 48'h0, "other page ignored");
    logPage = LOG_PAGE_ID;
    logFeatures = 8'h01;
    logReq = 1'b1;
    softReset = 1'b1;
    tick;
    logReq = 1'b0;
    softReset = 1'b0;
    tick;
    chk(48'(logValid), 48'h0, "request under soft reset");
    read_log(8'h01, 1'b0, 32'd3, 32'd5, 32'd2);
    read_log(8'h00, 1'b0, 32'd0, 32'd0, 32'd0);
    pulse_events(1, 1, 1);
    bist = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    tick;
    bist = '0;
    tick;
    read_log(8'h00, 1'b0, 32'd0, 32'd0, 32'd0);
    pulse_events(2, 2, 2);
    rst_n = 1'b0;
    tick;
    tick;
    rst_n = 1'b1;
    tick;
    chk(48'(preserveEn), 48'h1, "keep after power cycle");
    read_log(8'h00, 1'b1, 32'd0, 32'd0, 32'd0);
    $display("test counters done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    tick;
    test_reset;
    test_retain;
    test_nokeep;
    test_bist;
    test_counters;
    close_out;
  end
  // whole run is about two thousand cycles; this 25000-cycle bound is over twelve times that
  initial begin
    #200000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    close_out;
  end
endmodule
`default_nettype wire
